// ==== hdl/cfgm_monitor.sv ====
// Purpose: config map checksum monitor and interrupt flag manager
// Assumes: command decoder and lock register sit outside this block
// Notes: link side runs on the serial clock falling edge
`include "cfgm_consts.svh"

module cfgm_sync3 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // a change counts only once the last two stages agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q_o <= '0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q_o <= (s2 == s3) ? s3 : q_o;
        end
    end
endmodule

module cfgm_monitor import cfgm_pkg::*; #(
    parameter int MAP_BYTES = 16,
    parameter int IRQ_BYTE = 4,
    parameter int STP_CYC = `CFGM_STP_CYC
) (
    // system clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // serial link strobes, sampled on serial clock fall
    input wire logic SCK_I,
    input wire logic ADDR_DETECT_I,
    input wire logic STATUS_DONE_I,
    input wire logic IRQREG_START_I,
    input wire logic IRQREG_DONE_I,
    input wire logic ADC_READ_FIRST_I,
    output logic [2:0] STATUS_N_O,
    output logic [2:0] IRQREG_N_O,
    // pins from outside the clock domain
    input wire logic MODULATOR_CLOCK_I,
    input wire logic CS_N_I,
    input wire logic AVDD_OK_I,
    input wire logic DVDD_OK_I,
    // configuration and conversion events, system clock
    input wire logic [7:0] LOCK_KEY_I,
    input wire logic [MAP_BYTES*8-1:0] CFG_MAP_I,
    input wire logic FAST_START_I,
    input wire logic CONV_START_I,
    input wire logic DATA_READY_I,
    input wire logic CONT_MODE_I,
    input wire logic [15:0] DR_PERIOD_I,
    input wire logic [1:0] IRQ_MODE_I,
    input wire logic EN_STP_I,
    input wire logic MODULATOR_BITSTREAM_OUT_I,
    // write gate
    input wire logic WR_REQ_I,
    input wire logic [3:0] WR_ADDR_I,
    output logic WR_ACCEPT_O,
    // results
    output logic [15:0] CONFIG_CHECKSUM_VALUE_O,
    output logic IRQ_N_O
);
    localparam int NB = MAP_BYTES + 2;
    localparam int IW = $clog2(NB + 1);

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ b[i]) begin
                r = {r[14:0], 1'b0} ^ `CFGM_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // ---------------- link domain
    logic sck_fall;
    cfgm_flags_t st_pend;
    cfgm_flags_t irq_pend;
    logic [5:0] pend_l;
    cfgm_flags_t status_cap;
    cfgm_flags_t irq_cap;
    cfgm_flags_t st_mask_l;
    cfgm_flags_t irq_mask_l;
    logic st_tgl;
    logic irq_tgl;
    logic adc_tgl;

    assign sck_fall = ~SCK_I;

    // serial clock runs only inside frames: the flags here are fresh
    // from the fourth fall of a frame on, so capture must come later
    cfgm_sync3 #(.W(6)) u_pend_sync (
        .clk_i(sck_fall),
        .rst_n_i(RESETN_I),
        .d_i({st_pend, irq_pend}),
        .q_o(pend_l)
    );

    // masks keep the captured set so only reported flags get cleared;
    // they change at capture, well before the matching clear toggle
    always_ff @(posedge sck_fall or negedge RESETN_I) begin
        if (!RESETN_I) begin
            status_cap <= '0;
            st_mask_l <= '0;
            st_tgl <= 1'b0;
        end else if (ADDR_DETECT_I) begin
            status_cap <= pend_l[5:3];
            st_mask_l <= pend_l[5:3];
        end else if (STATUS_DONE_I) begin
            status_cap <= '0;
            st_tgl <= ~st_tgl;
        end
    end

    always_ff @(posedge sck_fall or negedge RESETN_I) begin
        if (!RESETN_I) begin
            irq_cap <= '0;
            irq_mask_l <= '0;
            irq_tgl <= 1'b0;
        end else if (IRQREG_START_I) begin
            irq_cap <= pend_l[2:0];
            irq_mask_l <= pend_l[2:0];
        end else if (IRQREG_DONE_I) begin
            irq_cap <= '0;
            irq_tgl <= ~irq_tgl;
        end
    end

    always_ff @(posedge sck_fall or negedge RESETN_I) begin
        if (!RESETN_I) begin
            adc_tgl <= 1'b0;
        end else if (ADC_READ_FIRST_I) begin
            adc_tgl <= ~adc_tgl;
        end
    end

    assign STATUS_N_O = ~status_cap;
    assign IRQREG_N_O = ~irq_cap;

    // ---------------- system domain synchronisers
    logic [3:0] pins_s;
    logic [8:0] link_s;
    logic mclk_q;
    logic cs_q;
    logic [2:0] tgl_q;
    logic mclk_edge;
    logic cs_fall;
    logic supplies_ok;
    logic st_clr;
    logic irq_clr;
    logic adc_clr;

    cfgm_sync3 #(.W(4)) u_pin_sync (
        .clk_i(CLK_I),
        .rst_n_i(RESETN_I),
        .d_i({MODULATOR_CLOCK_I, CS_N_I, AVDD_OK_I, DVDD_OK_I}),
        .q_o(pins_s)
    );

    cfgm_sync3 #(.W(9)) u_link_sync (
        .clk_i(CLK_I),
        .rst_n_i(RESETN_I),
        .d_i({st_tgl, irq_tgl, adc_tgl, st_mask_l, irq_mask_l}),
        .q_o(link_s)
    );

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mclk_q <= 1'b0;
            // matches the synchroniser's reset output, no false fall
            cs_q <= 1'b0;
            tgl_q <= '0;
        end else begin
            mclk_q <= pins_s[3];
            cs_q <= pins_s[2];
            tgl_q <= link_s[8:6];
        end
    end

    assign mclk_edge = pins_s[3] & ~mclk_q;
    assign cs_fall = ~pins_s[2] & cs_q;
    assign supplies_ok = pins_s[1] & pins_s[0];
    assign st_clr = link_s[8] ^ tgl_q[2];
    assign irq_clr = link_s[7] ^ tgl_q[1];
    assign adc_clr = link_s[6] ^ tgl_q[0];

    // ---------------- checksum engine
    logic locked;
    logic restart;
    cfgm_crc_e crc_state;
    logic [IW-1:0] byte_idx;
    logic [3:0] tick_cnt;
    logic [15:0] crc_acc;
    logic [15:0] crc_ref;
    logic ref_valid;
    logic err_latched;
    logic [7:0] cur_byte;
    logic [15:0] next_crc;
    logic run_start;
    logic last_byte;
    logic mismatch;

    assign locked = (LOCK_KEY_I != `CFGM_LOCK_KEY);
    assign restart = FAST_START_I;
    assign run_start = (tick_cnt == 4'h0) && mclk_edge;
    assign last_byte = (byte_idx == IW'(NB - 1));

    always_comb begin
        cur_byte = 8'h00;
        if (byte_idx < IW'(MAP_BYTES)) begin
            cur_byte = CFG_MAP_I[byte_idx*8 +: 8];
        end
        if (byte_idx == IW'(IRQ_BYTE)) begin
            cur_byte[`CFGM_IRQ_POS_DR] = 1'b1;
            cur_byte[`CFGM_IRQ_POS_CFG] = 1'b1;
            cur_byte[`CFGM_IRQ_POS_POR] = 1'b1;
        end
    end

    assign next_crc = crc_byte(crc_acc, cur_byte);
    assign mismatch = (crc_state == CRC_RUN) && last_byte && ref_valid &&
                      (next_crc != crc_ref);

    // one pass finishes in NB system clocks, far below one modulator
    // period, so a new pass never overlaps the previous one
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tick_cnt <= 4'h0;
        end else if (!locked || restart) begin
            tick_cnt <= 4'h0;
        end else if (mclk_edge) begin
            tick_cnt <= (tick_cnt == `CFGM_PERIOD_MCLK - 4'h1) ?
                        4'h0 : tick_cnt + 4'h1;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            crc_state <= CRC_IDLE;
            byte_idx <= '0;
            crc_acc <= `CFGM_CRC_INIT;
        end else if (!locked || restart) begin
            crc_state <= CRC_IDLE;
            byte_idx <= '0;
            crc_acc <= `CFGM_CRC_INIT;
        end else begin
            case (crc_state)
                CRC_IDLE: begin
                    if (run_start) begin
                        crc_state <= CRC_RUN;
                        byte_idx <= '0;
                        crc_acc <= `CFGM_CRC_INIT;
                    end
                end
                CRC_RUN: begin
                    crc_acc <= next_crc;
                    byte_idx <= byte_idx + IW'(1);
                    if (last_byte) begin
                        crc_state <= CRC_IDLE;
                    end
                end
                default: crc_state <= CRC_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            crc_ref <= `CFGM_CRC_FIELD_RST;
            ref_valid <= 1'b0;
            CONFIG_CHECKSUM_VALUE_O <= `CFGM_CRC_FIELD_RST;
        end else if (!locked || restart) begin
            ref_valid <= 1'b0;
            CONFIG_CHECKSUM_VALUE_O <= `CFGM_CRC_FIELD_RST;
        end else if (crc_state == CRC_RUN && last_byte) begin
            CONFIG_CHECKSUM_VALUE_O <= next_crc;
            if (!ref_valid) begin
                crc_ref <= next_crc;
                ref_valid <= 1'b1;
            end
        end
    end

    // error holds through later matching passes
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            err_latched <= 1'b0;
        end else if (!locked || restart) begin
            err_latched <= 1'b0;
        end else if (mismatch) begin
            err_latched <= 1'b1;
        end
    end

    assign WR_ACCEPT_O = WR_REQ_I &&
                         (!locked || WR_ADDR_I == `CFGM_ADDR_LOCK);

    // ---------------- flag sources, set wins over clear
    cfgm_flags_t set_flags;
    logic [15:0] stp_cnt;
    logic [15:0] dr_mcnt;
    logic dr_pin;
    logic por_pin;
    logic dr_auto;
    logic pin_any;
    logic pin_prio;

    assign set_flags[`CFGM_FLAG_DR] = DATA_READY_I;
    assign set_flags[`CFGM_FLAG_CFG] = err_latched;
    assign set_flags[`CFGM_FLAG_POR] = ~supplies_ok;

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_pend <= `CFGM_FLAGS_RST;
            irq_pend <= `CFGM_FLAGS_RST;
        end else begin
            st_pend <= (st_pend & ~(st_clr ? link_s[5:3] : 3'h0)) |
                       set_flags;
            irq_pend <= (irq_pend & ~(irq_clr ? link_s[2:0] : 3'h0)) |
                        set_flags;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            stp_cnt <= 16'h0000;
        end else if (CONV_START_I && EN_STP_I) begin
            stp_cnt <= 16'(STP_CYC);
        end else if (stp_cnt != 16'h0000) begin
            stp_cnt <= stp_cnt - 16'h0001;
        end
    end

    assign dr_auto = CONT_MODE_I && mclk_edge &&
                     (dr_mcnt + `CFGM_DR_EARLY_MCLK + 16'h0001 ==
                      DR_PERIOD_I);

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            dr_mcnt <= 16'h0000;
            dr_pin <= 1'b0;
        end else begin
            if (DATA_READY_I) begin
                dr_mcnt <= 16'h0000;
            end else if (mclk_edge) begin
                dr_mcnt <= dr_mcnt + 16'h0001;
            end
            dr_pin <= DATA_READY_I ||
                      (dr_pin && !adc_clr && !dr_auto);
        end
    end

    // power flag starts asserted: reset is the power-on event
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            por_pin <= 1'b1;
        end else begin
            por_pin <= !supplies_ok ||
                       (por_pin && !(cs_fall && supplies_ok));
        end
    end

    // the error outranks the bitstream; power outranks everything
    assign pin_prio = por_pin || err_latched;
    assign pin_any = IRQ_MODE_I[1] ? pin_prio :
                     (pin_prio || dr_pin || stp_cnt != 16'h0000);

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            IRQ_N_O <= 1'b0;
        end else if (IRQ_MODE_I[0]) begin
            IRQ_N_O <= pin_prio ? 1'b0 : MODULATOR_BITSTREAM_OUT_I;
        end else begin
            IRQ_N_O <= ~pin_any;
        end
    end

    // ---------------- checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence s_pass_end;
        crc_state == CRC_RUN && last_byte && locked && !restart;
    endsequence

    sequence s_unlock;
        !locked;
    endsequence

    a_unlock_zero: assert property (
        s_unlock |=> CONFIG_CHECKSUM_VALUE_O == 16'h0000 &&
                     crc_state == CRC_IDLE)
        else $error("checksum not cleared while unlocked");

    a_pass_publish: assert property (
        s_pass_end |=> CONFIG_CHECKSUM_VALUE_O == $past(next_crc))
        else $error("checksum result not published");

    a_ref_first: assert property (
        s_pass_end ##0 !ref_valid |=> ref_valid && crc_ref == $past(next_crc))
        else $error("first result not taken as reference");

    a_err_on_diff: assert property (
        s_pass_end ##0 ref_valid ##0 (next_crc != crc_ref)
        |=> err_latched ##1 !IRQ_N_O)
        else $error("mismatch did not raise error");

    a_err_hold: assert property (
        err_latched && locked && !restart |=> err_latched)
        else $error("error dropped while locked");

    a_unlock_pin: assert property (
        s_unlock ##1 !locked && !por_pin && IRQ_MODE_I == 2'b10
        |=> IRQ_N_O)
        else $error("pin not released on unlock");

    a_bitstream_ovr: assert property (
        err_latched && IRQ_MODE_I[0] |=> !IRQ_N_O)
        else $error("error did not override bitstream");

    a_stp_width: assert property (
        CONV_START_I && EN_STP_I |=> stp_cnt == 16'(STP_CYC))
        else $error("start pulse width wrong");

    a_write_gate: assert property (
        WR_REQ_I && locked && WR_ADDR_I != `CFGM_ADDR_LOCK |-> !WR_ACCEPT_O)
        else $error("locked write accepted");

    a_restart_clr: assert property (
        restart |=> !err_latched && !ref_valid)
        else $error("start command did not reset checksum");

    a_por_clear: assert property (
        por_pin && cs_fall && supplies_ok |=> !por_pin)
        else $error("power flag not cleared on select");

    a_period: assert property (
        run_start && locked && !restart |=> crc_state == CRC_RUN)
        else $error("pass not started on period");

    a_status_clr: assert property (
        @(posedge sck_fall) disable iff (!RESETN_I)
        STATUS_DONE_I && !ADDR_DETECT_I |=> STATUS_N_O == 3'h7)
        else $error("status flags not cleared");
endmodule

// ==== hdl/cfgm_consts.svh ====
// Purpose: constants for the configuration checksum monitor
// Assumes: 250 MHz system clock
// Notes: offsets are register addresses on the serial port
`ifndef CFGM_CONSTS_SVH
`define CFGM_CONSTS_SVH
`define CFGM_ADDR_FIRST 4'h1
`define CFGM_ADDR_IRQ 4'h5
`define CFGM_ADDR_LOCK 4'hD
`define CFGM_ADDR_CHECKSUM 4'hF
`define CFGM_LOCK_KEY 8'hA5
`define CFGM_CRC_POLY 16'h8005
`define CFGM_CRC_INIT 16'h0000
`define CFGM_CRC_FIELD_RST 16'h0000
`define CFGM_PERIOD_MCLK 4'hB
`define CFGM_DR_EARLY_MCLK 16'h0010
`define CFGM_FLAG_DR 2
`define CFGM_FLAG_CFG 1
`define CFGM_FLAG_POR 0
`define CFGM_FLAGS_RST 3'h1
`define CFGM_IRQ_POS_DR 6
`define CFGM_IRQ_POS_CFG 5
`define CFGM_IRQ_POS_POR 4
`define CFGM_CLK_MHZ 250
`define CFGM_STP_NS 100
`define CFGM_STP_CYC ((`CFGM_STP_NS * `CFGM_CLK_MHZ + 999) / 1000)
`endif

// ==== hdl/cfgm_pkg.sv ====
// Purpose: types for the configuration checksum monitor
// Assumes: nothing
// Notes: constants live in cfgm_consts.svh
package cfgm_pkg;
    typedef enum logic {CRC_IDLE, CRC_RUN} cfgm_crc_e;
    typedef logic [2:0] cfgm_flags_t;
endpackage

// ==== tb/cfgm_host_model.sv ====
// Purpose: host side of the serial link, frames with strobes
// Assumes: link logic samples strobes on the serial clock fall
// Notes: serial clock stands high between frames
module cfgm_host_model (
    // serial pins
    output logic sck_o,
    output logic cs_n_o,
    // frame strobes
    output logic addr_det_o,
    output logic st_done_o,
    output logic irq_start_o,
    output logic irq_done_o,
    output logic adc_first_o,
    // flags returned by the device
    input wire logic [2:0] status_n_i,
    input wire logic [2:0] irqreg_n_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sck_o = 1'h1;
        cs_n_o = 1'h1;
        {addr_det_o, st_done_o, irq_start_o, irq_done_o, adc_first_o} = 5'h0;
    end

    // kind 0 status only, 1 plus flag register, 2 plus result read
    task automatic frame(input int kind, output logic [2:0] st,
                         output logic [2:0] ir);
        int n;
        n = (kind == 0) ? 8 : 16;
        st = 3'h0;
        ir = 3'h0;
        cs_n_o = 1'h0;
        #60;
        for (int i = 1; i <= n; i++) begin
            // strobes move while the clock is high, sampled at the fall
            // device flags reach the link side after four falls
            addr_det_o = (i == 5);
            st_done_o = (i == 8);
            irq_start_o = (kind == 1) && (i == 9);
            irq_done_o = (kind == 1) && (i == 16);
            adc_first_o = (kind == 2) && (i == 9);
            #62.5 sck_o = 1'h0;
            #62.5;
            if (i == 5) begin
                st = status_n_i;
            end
            if (i == 9) begin
                ir = irqreg_n_i;
            end
            sck_o = 1'h1;
        end
        {addr_det_o, st_done_o, irq_start_o, irq_done_o, adc_first_o} = 5'h0;
        #60 cs_n_o = 1'h1;
        // select stays high between frames so each frame has a fall
        #64;
    endtask
endmodule

// ==== tb/cfgm_monitor_bench.sv ====
// Purpose: self-checking bench for the checksum monitor
// Assumes: map corruption is emulated on the map input
// Notes: modulator clock runs free, far slower than the pass
module cfgm_monitor_bench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [127:0] map_good =
        128'h0123_4567_89AB_CDEF_1357_9B8F_028F_4A6C;
    logic clk = 1'h0;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic sck, cs_n, addr_det, st_done, irq_start, irq_done, adc_first;
    logic [2:0] status_n, irqreg_n, st, ir;
    logic [7:0] lock_key = 8'hA5;
    logic [127:0] map = map_good;
    logic fast_start = 1'h0, conv_start = 1'h0, data_ready = 1'h0;
    logic cont_mode = 1'h0, en_stp = 1'h0, bitstream = 1'h0;
    logic [1:0] irq_mode = 2'h0;
    logic [15:0] dr_period = 16'h0014;
    logic wr_req = 1'h0, wr_accept, irq_n;
    logic [3:0] wr_addr = 4'h0;
    logic [15:0] checksum;
    logic supply_ok = 1'h1;
    int mismatches = 0, cmp_count = 0, cycles = 0;

    always #2 clk = ~clk;
    always #64 mclk = ~mclk;

    cfgm_monitor #(.MAP_BYTES(16), .IRQ_BYTE(4), .STP_CYC(25))
    cfgm_monitor_inst (
        .CLK_I(clk), .RESETN_I(rst_n),
        .SCK_I(sck), .ADDR_DETECT_I(addr_det),
        .STATUS_DONE_I(st_done), .IRQREG_START_I(irq_start),
        .IRQREG_DONE_I(irq_done), .ADC_READ_FIRST_I(adc_first),
        .STATUS_N_O(status_n), .IRQREG_N_O(irqreg_n),
        .MODULATOR_CLOCK_I(mclk), .CS_N_I(cs_n),
        .AVDD_OK_I(supply_ok), .DVDD_OK_I(supply_ok),
        .LOCK_KEY_I(lock_key), .CFG_MAP_I(map),
        .FAST_START_I(fast_start), .CONV_START_I(conv_start),
        .DATA_READY_I(data_ready), .CONT_MODE_I(cont_mode),
        .DR_PERIOD_I(dr_period), .IRQ_MODE_I(irq_mode),
        .EN_STP_I(en_stp), .MODULATOR_BITSTREAM_OUT_I(bitstream),
        .WR_REQ_I(wr_req), .WR_ADDR_I(wr_addr),
        .WR_ACCEPT_O(wr_accept),
        .CONFIG_CHECKSUM_VALUE_O(checksum), .IRQ_N_O(irq_n)
    );

    cfgm_host_model cfgm_host_model_inst (
        .sck_o(sck), .cs_n_o(cs_n), .addr_det_o(addr_det),
        .st_done_o(st_done), .irq_start_o(irq_start),
        .irq_done_o(irq_done), .adc_first_o(adc_first),
        .status_n_i(status_n), .irqreg_n_i(irqreg_n)
    );

    // own reference: bytes ascending, msb first, two zero bytes last
    function automatic logic [15:0] crc_ref(input logic [127:0] m);
        logic [15:0] c;
        logic [7:0] b;
        c = 16'h0000;
        for (int k = 0; k < 18; k++) begin
            b = (k < 16) ? m[8*k +: 8] : 8'h00;
            if (k == 4) begin
                b[6:4] = 3'h7;
            end
            for (int j = 7; j >= 0; j--) begin
                c = {c[14:0], 1'h0} ^ ((c[15] ^ b[j]) ? 16'h8005 : 16'h0000);
            end
        end
        return c;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'h1;
        cyc(1);
        s = 1'h0;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a hang costs a mismatch, the run takes about 6200 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'h1;
        cyc(10);
        check(checksum, 16'h0000, "checksum unlocked");
        check(16'(irq_n), 16'h0000, "power pin");
        cfgm_host_model_inst.frame(0, st, ir);
        check(16'(st), 16'h0006, "status at power up");
        check(16'(status_n), 16'h0007, "status cleared");
        cyc(2);
        check(16'(irq_n), 16'h0001, "power pin cleared");
        cfgm_host_model_inst.frame(0, st, ir);
        check(16'(st), 16'h0007, "status reread");
        supply_ok = 1'h0;
        cyc(8);
        check(16'(irq_n), 16'h0000, "supply drop");
        supply_ok = 1'h1;
        cyc(8);
        check(16'(irq_n), 16'h0000, "power held until select");
        cfgm_host_model_inst.frame(0, st, ir);
        check(16'(st[0]), 16'h0000, "power in status");
        check(16'(irq_n), 16'h0001, "power cleared by select");
        wr_req = 1'h1;
        for (int a = 0; a < 16; a++) begin
            wr_addr = 4'(a);
            cyc(1);
            check(16'(wr_accept), 16'h0001, "write open");
        end
        lock_key = 8'h00;
        for (int a = 0; a < 16; a++) begin
            wr_addr = 4'(a);
            cyc(1);
            check(16'(wr_accept), 16'(a == 13), "write locked");
        end
        wr_req = 1'h0;
        cyc(80);
        check(checksum, crc_ref(map), "first checksum");
        check(16'(irq_n), 16'h0001, "no error");
        map[0] = ~map[0];
        cyc(400);
        check(16'(irq_n), 16'h0000, "error pin");
        check(checksum, crc_ref(map), "recomputed");
        cfgm_host_model_inst.frame(1, st, ir);
        check(16'(st[1]), 16'h0000, "error in status");
        check(16'(ir[1]), 16'h0000, "error in register");
        check(16'(irqreg_n), 16'h0007, "register cleared");
        map = map_good;
        cyc(400);
        check(16'(irq_n), 16'h0000, "error held");
        cfgm_host_model_inst.frame(0, st, ir);
        check(16'(st[1]), 16'h0000, "status held");
        irq_mode = 2'h1;
        bitstream = 1'h1;
        cyc(5);
        check(16'(irq_n), 16'h0000, "error over bitstream");
        lock_key = 8'hA5;
        cyc(5);
        check(16'(irq_n), 16'h0001, "pin freed on unlock");
        check(checksum, 16'h0000, "checksum cleared");
        bitstream = 1'h0;
        cyc(5);
        check(16'(irq_n), 16'h0000, "bitstream on pin");
        irq_mode = 2'h0;
        cfgm_host_model_inst.frame(0, st, ir);
        check(16'(st[1]), 16'h0000, "flag until read");
        cfgm_host_model_inst.frame(0, st, ir);
        check(16'(st[1]), 16'h0001, "flag cleared by read");
        lock_key = 8'h00;
        cyc(80);
        map[0] = ~map[0];
        cyc(400);
        check(16'(irq_n), 16'h0000, "second error");
        pulse(fast_start);
        cyc(5);
        check(16'(irq_n), 16'h0001, "start clears error");
        cyc(800);
        check(16'(irq_n), 16'h0001, "new reference");
        check(checksum, crc_ref(map), "checksum after restart");
        lock_key = 8'hA5;
        map = map_good;
        cfgm_host_model_inst.frame(0, st, ir);
        pulse(data_ready);
        cyc(5);
        check(16'(irq_n), 16'h0000, "ready pin");
        cfgm_host_model_inst.frame(2, st, ir);
        check(16'(st[2]), 16'h0000, "ready in status");
        check(16'(irq_n), 16'h0001, "ready cleared by read");
        irq_mode = 2'h2;
        pulse(data_ready);
        cyc(5);
        check(16'(irq_n), 16'h0001, "ready masked");
        cfgm_host_model_inst.frame(2, st, ir);
        irq_mode = 2'h0;
        cont_mode = 1'h1;
        pulse(data_ready);
        cyc(5);
        check(16'(irq_n), 16'h0000, "ready continuous");
        cyc(200);
        check(16'(irq_n), 16'h0001, "ready auto clear");
        cont_mode = 1'h0;
        en_stp = 1'h1;
        pulse(conv_start);
        cyc(5);
        check(16'(irq_n), 16'h0000, "start pulse");
        cyc(30);
        check(16'(irq_n), 16'h0001, "start pulse ends");
        en_stp = 1'h0;
        pulse(conv_start);
        cyc(5);
        check(16'(irq_n), 16'h0001, "start pulse off");
        finish_test();
    end
endmodule
